//--- core/sci_baud_gen.sv
// Bit rate divider producing the receiver sample enable
`timescale 1ns/1ps
module sci_baud_gen
   import sci_rx_pkg::*;
(
   input  wire logic       pclk,            // Crystal derived clock
   input  wire logic       presetn,         // Async reset, active low
   input  wire logic [1:0] prescaler_field, // Prescaler code
   input  wire logic [2:0] rate_field,      // Power of two divisor code
   output logic            rt_tick          // One pulse per sample slot
);

   logic [3:0] pre_cnt;
   logic [6:0] rate_cnt;
   logic [1:0] quarter_cnt;
   logic [3:0] pre_last;
   logic [6:0] rate_last;
   logic       pre_tick;
   logic       rate_tick;

   always_comb begin
      case (prescaler_field)
         2'h0:    pre_last = 4'h0;
         2'h1:    pre_last = 4'h2;
         2'h2:    pre_last = 4'h3;
         default: pre_last = 4'hC;
      endcase
   end

   assign rate_last = 7'((8'h01 << rate_field) - 8'h01);
   // At or past the end, so a smaller divisor written mid-count takes hold at once
   assign pre_tick  = (pre_cnt >= pre_last);
   assign rate_tick = pre_tick && (rate_cnt >= rate_last);

   // one chain times the receiver sample slots
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_cnt     <= 4'h0;
         rate_cnt    <= 7'h00;
         quarter_cnt <= 2'h0;
         rt_tick     <= 1'b0;
      end else begin
         pre_cnt <= pre_tick ? 4'h0 : pre_cnt + 4'h1;
         if (pre_tick) begin
            rate_cnt <= rate_tick ? 7'h00 : rate_cnt + 7'h01;
         end
         if (rate_tick) begin
            quarter_cnt <= quarter_cnt + 2'h1;
         end
         rt_tick <= rate_tick && (quarter_cnt == 2'(PCLK_PER_RT - 1));
      end
   end

endmodule

//--- core/sci_receive_status_and_baud.sv
// Serial receiver status flags, data buffer and bit rate selection
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
module sci_receive_status_and_baud
   import sci_rx_pkg::*;
(
   input  wire logic        pclk,           // Bus and crystal derived clock
   input  wire logic        presetn,        // Async reset, active low
   input  wire logic        psel,           // APB select
   input  wire logic        penable,        // APB access phase
   input  wire logic        pwrite,         // APB write
   input  wire logic [7:0]  paddr,          // APB byte address
   input  wire logic [31:0] pwdata,         // APB write data
   output logic [31:0]      prdata,         // APB read data
   output logic             pready,         // APB ready
   output logic             pslverr,        // APB error, unmapped address
   input  wire logic        receive_pin,    // Serial input, idles high
   output logic [7:0]       transmit_byte,  // Byte written for transmit
   output logic             transmit_load,  // Pulse on data buffer write
   output logic [2:0]       rate_divisor_field, // Shared rate select
   output logic [1:0]       prescaler_field,    // Shared prescaler
   output logic             receiver_irq,   // Receive request level
   output logic             error_irq       // Error request level
);

   // -----------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------
   logic [CTL_WIDTH-1:0] control;
   logic [7:0]  data_buffer;
   logic        received_ninth_bit;
   logic        receiver_full_flag;
   logic        idle_flag;
   logic        overrun_flag;
   logic        noise_flag;
   logic        framing_error_flag;
   logic        parity_error_flag;
   logic        break_detect_flag;
   logic        reception_in_progress_flag;
   logic [5:0]  seen_one;
   logic        seen_two;
   logic        idle_armed;
   logic        break_armed;
   logic        rx_en_q;
   rx_state_t   state;
   logic [3:0]  rt_cnt;
   logic [3:0]  bit_cnt;
   logic [1:0]  samples;
   logic [8:0]  shreg;
   logic        noise_seen;
   logic        any_one;
   logic [7:0]  ones_cnt;
   logic        rt_tick;
   logic        rx_en;
   logic        access;
   logic        rd_one;
   logic        rd_two;
   logic        rd_data;
   logic        wr_data;
   logic        mapped;
   logic        vote;
   logic        at_vote;
   logic        bit_end;
   logic [3:0]  frame_bits;
   logic        frame_done;
   logic        is_break;
   logic        bad_parity;
   logic [8:0]  word;
   logic        load_ok;
   logic        idle_hit;
   logic        false_start;
   logic [31:0] rd_mux;

   assign rx_en = control[CTL_RX_EN];

   // -----------------------------------------------------------------
   // Bit rate generator
   // -----------------------------------------------------------------
   sci_baud_gen sci_baud_gen_i (
      .pclk            (pclk),
      .presetn         (presetn),
      .prescaler_field (prescaler_field),
      .rate_field      (rate_divisor_field),
      .rt_tick         (rt_tick)
   );

   // -----------------------------------------------------------------
   // APB slave
   // -----------------------------------------------------------------
   // Zero wait states; read data is captured in the setup cycle
   assign pready  = 1'b1;
   assign access  = psel && penable;
   assign mapped  = (paddr == OFF_STATUS_ONE) || (paddr == OFF_STATUS_TWO) ||
                    (paddr == OFF_DATA_BUFFER) || (paddr == OFF_RATE_SELECT) ||
                    (paddr == OFF_CONTROL);
   assign pslverr = access && !mapped;
   assign rd_one  = access && !pwrite && (paddr == OFF_STATUS_ONE);
   assign rd_two  = access && !pwrite && (paddr == OFF_STATUS_TWO);
   assign rd_data = access && !pwrite && (paddr == OFF_DATA_BUFFER);
   assign wr_data = access && pwrite && (paddr == OFF_DATA_BUFFER);

   // Read multiplexer
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (paddr)
         OFF_STATUS_ONE:  rd_mux[5:0] = {receiver_full_flag, idle_flag,
                                         overrun_flag, noise_flag,
                                         framing_error_flag, parity_error_flag};
         OFF_STATUS_TWO:  rd_mux[1:0] = {break_detect_flag,
                                         reception_in_progress_flag};
         OFF_DATA_BUFFER: rd_mux[7:0] = data_buffer;
         OFF_RATE_SELECT: rd_mux[5:0] = {prescaler_field, 1'b0,
                                         rate_divisor_field};
         OFF_CONTROL:     rd_mux[10:0] = {received_ninth_bit, control};
         default:         rd_mux = 32'h0000_0000;
      endcase
   end

   // Read data register, loaded in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= rd_mux;
      end
   end

   // Control and rate select registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         control            <= CONTROL_RESET;
         prescaler_field    <= PRESCALE_RESET;
         rate_divisor_field <= RATE_RESET;
      end else if (access && pwrite) begin
         if (paddr == OFF_CONTROL) begin
            control <= pwdata[CTL_WIDTH-1:0];
         end
         if (paddr == OFF_RATE_SELECT) begin
            prescaler_field    <= pwdata[RATE_PRE_LSB+1:RATE_PRE_LSB];
            rate_divisor_field <= pwdata[2:0];
         end
      end
   end

   // transmit side storage, untouched by reset
   always_ff @(posedge pclk) begin
      if (wr_data) begin
         transmit_byte <= pwdata[7:0];
      end
   end

   // Transmit load strobe
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         transmit_load <= 1'b0;
      end else begin
         transmit_load <= wr_data;
      end
   end

   // -----------------------------------------------------------------
   // Receive frame engine
   // -----------------------------------------------------------------
   assign at_vote    = rt_tick && (rt_cnt == 4'(RT_SAMPLE_C));
   // Slot nine is taken live from the pin, slots seven and eight from the shifter
   assign vote       = (receive_pin & samples[1]) | (receive_pin & samples[0]) |
                       (samples[1] & samples[0]);
   assign bit_end    = rt_tick && (rt_cnt == 4'(RT_PER_BIT - 1));
   assign frame_bits = control[CTL_NINE] ? 4'h9 : 4'h8;
   assign frame_done = (state == RX_STOP) && at_vote;
   assign false_start = (state == RX_START) && at_vote && vote;
   assign is_break   = frame_done && !vote && !any_one;
   assign word       = control[CTL_NINE] ? shreg : {shreg[8], shreg[8:1]};
   assign bad_parity = control[CTL_PAR_EN] &&
                       ((^word[7:0] ^ (control[CTL_NINE] & word[8])) !=
                        control[CTL_PAR_ODD]);
   // a held byte blocks the new one
   assign load_ok    = frame_done && !receiver_full_flag;

   // Sample shift and bit counters
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state      <= RX_HUNT;
         rt_cnt     <= 4'h0;
         bit_cnt    <= 4'h0;
         samples    <= 2'h0;
         shreg      <= 9'h000;
         noise_seen <= 1'b0;
         any_one    <= 1'b0;
      end else if (!rx_en) begin
         state <= RX_HUNT;
      end else if (rt_tick) begin
         rt_cnt <= rt_cnt + 4'h1;
         if (rt_cnt >= 4'(RT_SAMPLE_A) && rt_cnt <= 4'(RT_SAMPLE_C)) begin
            samples <= {receive_pin, samples[1]};
         end
         case (state)
            RX_HUNT: begin
               // low in the first slot starts a frame
               rt_cnt <= 4'h1;
               if (!receive_pin) begin
                  state      <= RX_START;
                  rt_cnt     <= 4'h2;
                  noise_seen <= 1'b0;
                  any_one    <= 1'b0;
                  bit_cnt    <= 4'h0;
               end
            end
            RX_START: begin
               if (false_start) begin
                  state <= RX_HUNT;
               end else if (bit_end) begin
                  state <= RX_DATA;
               end
            end
            RX_DATA: begin
               if (at_vote) begin
                  shreg   <= {vote, shreg[8:1]};
                  any_one <= any_one | vote;
                  bit_cnt <= bit_cnt + 4'h1;
               end
               if (bit_end && bit_cnt == frame_bits) begin
                  state <= RX_STOP;
               end
            end
            RX_STOP: begin
               if (at_vote) begin
                  state <= RX_HUNT;
               end
            end
            default: state <= RX_HUNT;
         endcase
         if (at_vote && (receive_pin != samples[1] || samples[1] != samples[0])) begin
            noise_seen <= 1'b1;
         end
      end
   end

   // Idle line counter, ones seen while hunting
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ones_cnt <= 8'h00;
         idle_hit <= 1'b0;
      end else begin
         idle_hit <= 1'b0;
         if (!rx_en || state != RX_HUNT || !receive_pin) begin
            ones_cnt <= 8'h00;
         end else if (rt_tick && ones_cnt != 8'(IDLE_RT_COUNT)) begin
            ones_cnt <= ones_cnt + 8'h01;
            idle_hit <= (ones_cnt == 8'(IDLE_RT_COUNT - 1));
         end
      end
   end

   // -----------------------------------------------------------------
   // Flag clearing snapshots
   // -----------------------------------------------------------------
   // only flags seen at the status read may clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seen_one <= 6'h00;
         seen_two <= 1'b0;
      end else if (rd_data) begin
         seen_one <= 6'h00;
         seen_two <= 1'b0;
      end else begin
         // Keep what the read returned, so a flag set after the setup survives
         if (rd_one) begin
            seen_one <= prdata[5:0];
         end
         if (rd_two) begin
            seen_two <= prdata[ST2_BREAK];
         end
      end
   end

   // -----------------------------------------------------------------
   // Status flags, setting wins over clearing except for in-progress, where clearing wins
   // -----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         receiver_full_flag <= 1'b0;
         overrun_flag       <= 1'b0;
         noise_flag         <= 1'b0;
         framing_error_flag <= 1'b0;
         parity_error_flag  <= 1'b0;
      end else begin
         receiver_full_flag <= load_ok ||
            (receiver_full_flag && !(rd_data && seen_one[ST1_FULL]));
         overrun_flag <= (frame_done && receiver_full_flag) ||
            (overrun_flag && !(rd_data && seen_one[ST1_OVERRUN]));
         noise_flag <= (load_ok && noise_seen) ||
            (noise_flag && !(rd_data && seen_one[ST1_NOISE]));
         framing_error_flag <= (load_ok && !vote) ||
            (framing_error_flag && !(rd_data && seen_one[ST1_FRAMING]));
         parity_error_flag <= (load_ok && bad_parity) ||
            (parity_error_flag && !(rd_data && seen_one[ST1_PARITY]));
      end
   end

   // Idle flag and its arming
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idle_flag  <= 1'b0;
         idle_armed <= 1'b0;
         rx_en_q    <= 1'b0;
      end else begin
         rx_en_q <= rx_en;
         idle_flag <= (idle_hit && idle_armed) ||
            (idle_flag && !(rd_data && seen_one[ST1_IDLE]));
         if (load_ok) begin
            idle_armed <= 1'b1;
         end else if ((rx_en && !rx_en_q) || idle_hit ||
                      (rd_data && seen_one[ST1_IDLE])) begin
            idle_armed <= 1'b0;
         end
      end
   end

   // Break flag and in-progress flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         break_detect_flag          <= 1'b0;
         break_armed                <= 1'b1;
         reception_in_progress_flag <= 1'b0;
      end else begin
         // status two read pair clears break
         break_detect_flag <= (load_ok && is_break && break_armed) ||
            (break_detect_flag && !(rd_data && seen_two));
         // ones on the line rearm break
         if (is_break) begin
            break_armed <= 1'b0;
         end else if (rx_en && receive_pin) begin
            break_armed <= 1'b1;
         end
         // set on first low slot; drop on false start
         if (!rx_en || false_start || idle_hit || frame_done) begin
            reception_in_progress_flag <= 1'b0;
         end else if (rt_tick && state == RX_HUNT && !receive_pin) begin
            reception_in_progress_flag <= 1'b1;
         end
      end
   end

   // a break clears the ninth bit
   always_ff @(posedge pclk) begin
      if (load_ok) begin
         data_buffer        <= word[7:0];
         received_ninth_bit <= is_break ? 1'b0 : word[8];
      end
   end

   // -----------------------------------------------------------------
   // Interrupt requests; break and in-progress never request
   // -----------------------------------------------------------------
   // receive request; idle request
   assign receiver_irq = (receiver_full_flag && control[CTL_RIE]) ||
                         (idle_flag && control[CTL_IDLE_LINE_INTERRUPT_ENABLE]);
   assign error_irq = (overrun_flag && control[CTL_OVERRUN_INTERRUPT_ENABLE]) ||
                      (noise_flag && control[CTL_NOISE_INTERRUPT_ENABLE]) ||
                      (framing_error_flag && control[CTL_FRAMING_INTERRUPT_ENABLE]) ||
                      (parity_error_flag && control[CTL_PARITY_INTERRUPT_ENABLE]);

endmodule

//--- core/sci_rx_pkg.sv
// Register map, field layout and timing constants of the serial receive block
package sci_rx_pkg;

   // -----------------------------------------------------------------
   // Register byte offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] OFF_STATUS_ONE  = 8'h10;
   localparam logic [7:0] OFF_STATUS_TWO  = 8'h14;
   localparam logic [7:0] OFF_DATA_BUFFER = 8'h18;
   localparam logic [7:0] OFF_RATE_SELECT = 8'h1C;
   localparam logic [7:0] OFF_CONTROL     = 8'h20;

   // -----------------------------------------------------------------
   // Status one bit positions
   // -----------------------------------------------------------------
   localparam int ST1_FULL    = 5;
   localparam int ST1_IDLE    = 4;
   localparam int ST1_OVERRUN = 3;
   localparam int ST1_NOISE   = 2;
   localparam int ST1_FRAMING = 1;
   localparam int ST1_PARITY  = 0;

   // -----------------------------------------------------------------
   // Status two, rate select and control bit positions
   // -----------------------------------------------------------------
   localparam int ST2_BREAK    = 1;
   localparam int ST2_RPF      = 0;
   localparam int RATE_PRE_LSB = 4;
   localparam int CTL_RX_EN    = 0;
   localparam int CTL_RIE      = 1;
   localparam int CTL_IDLE_LINE_INTERRUPT_ENABLE     = 2;
   localparam int CTL_OVERRUN_INTERRUPT_ENABLE     = 3;
   localparam int CTL_NOISE_INTERRUPT_ENABLE     = 4;
   localparam int CTL_FRAMING_INTERRUPT_ENABLE     = 5;
   localparam int CTL_PARITY_INTERRUPT_ENABLE     = 6;
   localparam int CTL_NINE     = 7;
   localparam int CTL_PAR_EN   = 8;
   localparam int CTL_PAR_ODD  = 9;
   localparam int CTL_NINTH    = 10;
   localparam int CTL_WIDTH    = 10;

   // -----------------------------------------------------------------
   // Reset values and timing
   // -----------------------------------------------------------------
   localparam logic [9:0] CONTROL_RESET  = 10'h000;
   localparam logic [1:0] PRESCALE_RESET = 2'h0;
   localparam logic [2:0] RATE_RESET     = 3'h0;
   localparam int RT_PER_BIT     = 16;  // receiver samples per bit time
   localparam int PCLK_PER_RT    = 4;   // 64 clocks per bit at divisor one
   localparam int IDLE_BITS      = 10;  // ones that make an idle line
   localparam int IDLE_RT_COUNT  = IDLE_BITS * RT_PER_BIT;
   localparam int RT_SAMPLE_A    = 7;
   localparam int RT_SAMPLE_B    = 8;
   localparam int RT_SAMPLE_C    = 9;

   // Receiver frame states
   typedef enum logic [3:0] {
      RX_HUNT  = 4'b0001,
      RX_START = 4'b0010,
      RX_DATA  = 4'b0100,
      RX_STOP  = 4'b1000
   } rx_state_t;

endpackage

//--- test/sci_receive_status_and_baud_test.sv
// Self-checking bench for the serial receive status and rate block
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_fail++; \
   $display("wrong value at %0t: %h, expected %h", $time, got, exp); end end
module sci_receive_status_and_baud_test import sci_rx_pkg::*; ;
   localparam int BIT = RT_PER_BIT * PCLK_PER_RT; // Clocks per bit
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slverr;
   logic        receive_pin, transmit_load, receiver_irq, error_irq;
   logic [7:0]  paddr, transmit_byte;
   logic [31:0] pwdata, prdata, rdata;
   logic [2:0]  rate_divisor_field;
   logic [1:0]  prescaler_field;
   int          n_fail = 0;
   int          samples_checked = 0;
   sci_receive_status_and_baud sci_receive_status_and_baud_i (.pclk, .presetn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .receive_pin,
      .transmit_byte, .transmit_load, .rate_divisor_field, .prescaler_field,
      .receiver_irq, .error_irq);
   serial_sender serial_sender_i (.pclk, .line(receive_pin));
   // Clock and watchdog
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   initial begin
      repeat (40000) @(posedge pclk);
      n_fail++;
      test_done;
   end
   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdata = prdata;
      slverr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(rdata & m, e)
   endtask
   task automatic wait_bits(input int n);
      repeat (n * BIT) @(posedge pclk);
   endtask
   // Reset values, then every prescaler code
   task automatic t_rate;
      rd(OFF_STATUS_ONE, 32'hFF, 32'h0);
      rd(OFF_STATUS_TWO, 32'h2, 32'h0);
      rd(OFF_RATE_SELECT, 32'hFF, 32'h0);
      for (int c = 0; c < 4; c++) begin
         apb(1'b1, OFF_RATE_SELECT, 32'(c * 16 + 7 - c));
         `CHK({prescaler_field, rate_divisor_field}, 5'(c * 8 + 7 - c))
         rd(OFF_RATE_SELECT, 32'h37, 32'(c * 16 + 7 - c));
      end
      apb(1'b1, OFF_RATE_SELECT, 32'h0);
      $display("rate done");
   endtask
   // Arrival, idle line and the read pair that clears them
   task automatic t_idle;
      apb(1'b1, OFF_CONTROL, 32'h2F);
      wait_bits(12);
      rd(OFF_STATUS_ONE, 32'hFF, 32'h0);
      fork
         serial_sender_i.send(8'hA5, 1'b1, BIT);
         begin
            wait_bits(3);
            rd(OFF_STATUS_TWO, 32'h1, 32'h1);
         end
      join
      `CHK(receiver_irq, 1'b1)
      wait_bits(12);
      rd(OFF_STATUS_ONE, 32'hFF, 32'h30);
      rd(OFF_DATA_BUFFER, 32'hFF, 32'hA5);
      rd(OFF_STATUS_ONE, 32'hFF, 32'h0);
      `CHK(receiver_irq, 1'b0)
      wait_bits(12);
      rd(OFF_STATUS_ONE, 32'hFF, 32'h0);
      $display("idle done");
   endtask
   // Overrun, plain and after a late data read
   task automatic t_overrun;
      serial_sender_i.send(8'h3C, 1'b1, BIT);
      serial_sender_i.send(8'h5A, 1'b1, BIT);
      rd(OFF_STATUS_ONE, 32'h2F, 32'h28);
      `CHK(error_irq, 1'b1)
      rd(OFF_DATA_BUFFER, 32'hFF, 32'h3C);
      rd(OFF_STATUS_ONE, 32'h2F, 32'h0);
      serial_sender_i.send(8'h11, 1'b1, BIT);
      rd(OFF_STATUS_ONE, 32'h2F, 32'h20);
      serial_sender_i.send(8'h22, 1'b1, BIT);
      rd(OFF_DATA_BUFFER, 32'hFF, 32'h11);
      rd(OFF_STATUS_ONE, 32'h2F, 32'h08);
      rd(OFF_DATA_BUFFER, 32'hFF, 32'h11);
      rd(OFF_STATUS_ONE, 32'h2F, 32'h0);
      $display("overrun done");
   endtask
   // Break, then a plain framing error
   task automatic t_errors;
      for (int k = 0; k < 2; k++) begin
         serial_sender_i.send(8'(k * 8'h81), 1'b0, BIT);
         rd(OFF_STATUS_ONE, 32'h2F, 32'h22);
         `CHK(error_irq, 1'b1)
         rd(OFF_STATUS_TWO, 32'h2, k ? 32'h0 : 32'h2);
         rd(OFF_DATA_BUFFER, 32'hFF, 32'(k * 8'h81));
         rd(OFF_STATUS_TWO, 32'h2, 32'h0);
         rd(OFF_STATUS_ONE, 32'h2F, 32'h0);
      end
      $display("errors done");
   endtask
   // Split data storage, unmapped access, slow prescaler
   task automatic t_data;
      apb(1'b1, OFF_DATA_BUFFER, 32'h5A);
      `CHK(transmit_byte, 8'h5A)
      rd(OFF_DATA_BUFFER, 32'hFF, 32'h81);
      rd(8'h40, 32'hFFFFFFFF, 32'h0);
      `CHK(slverr, 1'b1)
      apb(1'b1, OFF_RATE_SELECT, 32'h10);
      serial_sender_i.send(8'hC3, 1'b1, 3 * BIT);
      rd(OFF_DATA_BUFFER, 32'hFF, 32'hC3);
      $display("data done");
   endtask
   // Even parity in the top bit: wrong, then right
   task automatic t_parity;
      rd(OFF_STATUS_ONE, 32'h2F, 32'h20);
      rd(OFF_DATA_BUFFER, 32'hFF, 32'hC3);
      apb(1'b1, OFF_CONTROL, 32'h17F);
      serial_sender_i.send(8'h01, 1'b1, 3 * BIT);
      rd(OFF_STATUS_ONE, 32'h2F, 32'h21);
      `CHK(error_irq, 1'b1)
      rd(OFF_DATA_BUFFER, 32'hFF, 32'h01);
      serial_sender_i.send(8'h81, 1'b1, 3 * BIT);
      rd(OFF_STATUS_ONE, 32'h2F, 32'h20);
      rd(OFF_DATA_BUFFER, 32'hFF, 32'h81);
      $display("parity done");
   endtask
   task automatic test_done;
      $display("checks %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Reset, then the scenarios in turn
   initial begin
      {psel, penable, pwrite, paddr, pwdata} <= '0;
      presetn <= 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_rate;
      t_idle;
      t_overrun;
      t_errors;
      t_data;
      t_parity;
      test_done;
   end
endmodule

//--- test/sci_rx_checker.sv
// Port checker for the serial receive status and rate block
`timescale 1ns/1ps
module sci_rx_checker (
   input wire logic        pclk,               // Clock
   input wire logic        presetn,            // Reset
   input wire logic        psel,               // Select
   input wire logic        penable,            // Access
   input wire logic        pwrite,             // Write
   input wire logic [7:0]  paddr,              // Address
   input wire logic [31:0] pwdata,             // Wdata
   input wire logic [31:0] prdata,             // Rdata
   input wire logic        pready,             // Ready
   input wire logic        pslverr,            // Error
   input wire logic [7:0]  transmit_byte,      // Tx byte
   input wire logic        transmit_load,      // Tx strobe
   input wire logic [2:0]  rate_divisor_field, // Rate
   input wire logic [1:0]  prescaler_field,    // Prescale
   input wire logic        receiver_irq,       // Rx irq
   input wire logic        error_irq           // Err irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Decoded transfers
   logic acc;
   logic rd1;
   logic rw;
   assign acc = psel && penable && pready;
   assign rd1 = acc && !pwrite && paddr == 8'h10;
   assign rw  = acc && pwrite && paddr == 8'h1C;
   AST_UNMAPPED: assert property (
      acc && !pwrite && paddr > 8'h20 |-> pslverr && prdata == 32'h0) else $error("unmapped");
   AST_TX_LOAD: assert property (
      acc && pwrite && paddr == 8'h18 |=> transmit_load && transmit_byte == $past(pwdata[7:0]))
      else $error("tx byte");
   AST_RATE_WRITE: assert property (rw |=>
      {prescaler_field, rate_divisor_field} == {$past(pwdata[5:4]), $past(pwdata[2:0])})
      else $error("rate write");
   AST_RATE_HOLD: assert property (
      !rw |=> $stable(prescaler_field) && $stable(rate_divisor_field)) else $error("rate hold");
   AST_RATE_READ: assert property (
      acc && !pwrite && paddr == 8'h1C |-> prdata[5:0] == {prescaler_field, 1'b0,
      rate_divisor_field}) else $error("rate read");
   AST_RESET_CLEAR: assert property ($rose(presetn) |-> prescaler_field == 2'h0 &&
      rate_divisor_field == 3'h0 && !receiver_irq && !error_irq) else $error("reset");
   AST_RX_IRQ: assert property (
      rd1 && prdata[5:4] == 2'h0 |-> !$past(receiver_irq)) else $error("rx irq");
   AST_ERR_IRQ: assert property (
      rd1 && prdata[3:0] == 4'h0 |-> !$past(error_irq)) else $error("err irq");
   cover property (rw);
   cover property (rd1 && prdata[5]);
   cover property (error_irq);
endmodule
bind sci_receive_status_and_baud sci_rx_checker sci_rx_checker_i (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .transmit_byte,
   .transmit_load, .rate_divisor_field, .prescaler_field, .receiver_irq, .error_irq);

//--- test/serial_sender.sv
// Remote serial transmitter driving the receive pin
`timescale 1ns/1ps
module serial_sender (
   input wire logic pclk, // Bit timing clock
   output logic     line  // Serial line, idles high
);
   // Line rests high between frames
   initial line = 1'b1;
   // Start, data LSB first, stop, then one idle bit
   task automatic send(input logic [7:0] data, input logic stop, input int clocks);
      logic [10:0] frame;
      frame = {1'b1, stop, data, 1'b0};
      for (int i = 0; i < 11; i++) begin
         line <= frame[i];
         repeat (clocks) @(posedge pclk);
      end
   endtask
endmodule
